//--- ipr_access_ordering.sv
// internal register access ordering: scoreboard, barrier, issue gates, shadow map
`timescale 1ns/1ps
// Overview of operation
// - later explicit writer of a busy group waits in map until earlier issues (low group) or retires (high group).
// - no scoreboard checks between instructions in the same fetch block.
// - translation entry/tag writes are ordered before later memory ops.
// - stalling return blocks fetch, issue, retire of newer until it retires.
// - privileged register reads and writes wait while store bubbles busy.
// - loads gated by load-bubble busy and by low scoreboard bits in loadSbDep; no order against reads.
// - shadow registers replace R4-R7, R20-R23 in firmware mode with shadow bit.
// - firmware call writes return address into a shadow register.
// - fp status bits set on every exceptional condition.
// - clear status or enabled trap raises arithmetic firmware trap.
// - exception summary carries what the trap handler needs.
// - fp control read runs in the fp unit without firmware.
// - fp control write fills first latch on execute, second on retire.
// - fp queue has no scoreboard for fp control readers.
// - fp control write traps to its own entry after first latch.
// - all reads of written registers use the second copy.
// - a writer entering the queue sets its unmasked scoreboard bits.
module ipr_access_ordering
   import ipr_pkg::*;
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_b,
   // map stage: instruction about to enter the issue queue
   input  wire logic               mapValid,
   input  wire logic [VA_W-1:0]    mapAddr,
   input  wire logic               mapIsWrite,
   input  wire logic               mapIsRead,
   input  wire logic               mapIsMem,
   input  wire logic               mapIsStallRet,
   input  wire logic [SB_BITS-1:0] mapSbMask,
   // scoreboard clearing events
   input  wire logic [SB_BITS-1:0] wrIssueBits,
   input  wire logic [SB_BITS-1:0] wrRetireBits,
   input  wire logic [SB_BITS-1:0] wrAbortBits,
   // barrier release
   input  wire logic               stallRetRetire,
   input  wire logic               stallRetAbort,
   // issue candidates and memory unit busy
   input  wire logic               privRdy,
   input  wire logic               loadRdy,
   input  wire logic [SB_ISSUE_W-1:0] loadSbDep,
   input  wire logic               storeBubbleBusy,
   input  wire logic               loadBubbleBusy,
   // shadow register mapping
   input  wire logic               fwMode,
   input  wire logic [1:0]         shadowEnable,
   input  wire logic [4:0]         srcReg,
   input  wire logic               fwCall,
   // fp control register
   input  wire logic               fpWrExec,
   input  wire logic [FP_W-1:0]    fpWrData,
   input  wire logic               fpWrRetire,
   input  wire logic               fpWrAbort,
   input  wire logic               fpExcValid,
   input  wire logic [FP_W-1:0]    fpExcCond,
   input  wire logic [FP_W-1:0]    fpTrapEn,
   // outputs
   output logic                    mapStall_r,
   output logic                    mapEnter_r,
   output logic                    fetchHold_r,
   output logic                    privIssue_r,
   output logic                    loadIssue_r,
   output logic [SB_BITS-1:0]      sbBits_r,
   output logic                    useShadow_r,
   output logic [2:0]              shadowIdx_r,
   output logic                    linkWrite_r,
   output logic [FP_W-1:0]         fpCtlRd_r,
   output logic [1:0]              trapEntry_r,
   output logic [EXC_W-1:0]        excSummary_r
);
   typedef struct packed {
      logic [SB_BITS-1:0]   sb;
      logic [VA_W-FBLK_LSB-1:0] lastBlk;
      logic                 blkValid;
      ipr_barrier_t         bar;
      logic                 stall;
      logic                 enter;
      logic                 privIss;
      logic                 loadIss;
      logic                 shadow;
      logic [2:0]           shIdx;
      logic                 link;
   } ipr_state_t;
   ipr_state_t st_r, st_nxt;

   function automatic logic [VA_W-FBLK_LSB-1:0] fetchBlk(input logic [VA_W-1:0] a);
      fetchBlk = a[VA_W-1:FBLK_LSB];
   endfunction : fetchBlk

   function automatic logic isShadowReg(input logic [4:0] r);
      isShadowReg = (r >= 5'h04 && r <= 5'h07) || (r >= 5'h14 && r <= 5'h17);
   endfunction : isShadowReg

   logic sameBlk;
   logic sbHit;
   logic shadowOn;
   logic [SB_BITS-1:0] sbCleared;

   always_comb begin
      sameBlk   = st_r.blkValid && (fetchBlk(mapAddr) == st_r.lastBlk);
      // low group frees at writer issue, high group at retire
      sbCleared = wrAbortBits | wrRetireBits
                | {{(SB_BITS-SB_ISSUE_W){1'b0}}, wrIssueBits[SB_ISSUE_W-1:0]};
      // same-block instructions skip the check; firmware keeps that safe
      sbHit     = |(st_r.sb & mapSbMask) && !sameBlk;
      shadowOn  = fwMode && shadowEnable[SDE_BIT];
   end

   always_comb begin
      st_nxt         = st_r;
      st_nxt.sb      = st_r.sb & ~sbCleared;
      st_nxt.stall   = 1'b0;
      st_nxt.enter   = 1'b0;
      if (mapValid && (mapIsWrite || mapIsRead || mapIsMem)) begin
         if (st_r.bar == IPR_STALL) begin
            st_nxt.stall = 1'b1;
         end else if (sbHit) begin
            st_nxt.stall = 1'b1;
         end else begin
            st_nxt.enter    = 1'b1;
            st_nxt.lastBlk  = fetchBlk(mapAddr);
            st_nxt.blkValid = 1'b1;
            if (mapIsWrite) begin
               st_nxt.sb = st_nxt.sb | mapSbMask;
            end
            if (mapIsStallRet) begin
               st_nxt.bar = IPR_STALL;
            end
         end
      end
      if (stallRetRetire || stallRetAbort) begin
         st_nxt.bar = IPR_RUN;
      end
      st_nxt.privIss = privRdy && !storeBubbleBusy;
      // loads ignore store bubbles and may pass a held read
      st_nxt.loadIss = loadRdy && !loadBubbleBusy
                     && !(|(st_r.sb[SB_ISSUE_W-1:0] & loadSbDep));
      st_nxt.shadow  = shadowOn && isShadowReg(srcReg);
      st_nxt.shIdx   = {srcReg[4], srcReg[1:0]};
      st_nxt.link    = fwCall && shadowOn;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{sb: SB_RST, lastBlk: 12'h000, blkValid: 1'b0, bar: IPR_RUN,
                   stall: 1'b0, enter: 1'b0, privIss: 1'b0, loadIss: 1'b0,
                   shadow: 1'b0, shIdx: 3'h0, link: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mapStall_r  = st_r.stall;
   assign mapEnter_r  = st_r.enter;
   assign fetchHold_r = (st_r.bar == IPR_STALL);
   assign privIssue_r = st_r.privIss;
   assign loadIssue_r = st_r.loadIss;
   assign sbBits_r    = st_r.sb;
   assign useShadow_r = st_r.shadow;
   assign shadowIdx_r = st_r.shIdx;
   assign linkWrite_r = st_r.link;

   ipr_fp_ctl uFpCtl (
      .clock        (clock),
      .rst_b        (rst_b),
      .fpWrExec     (fpWrExec),
      .fpWrData     (fpWrData),
      .fpWrRetire   (fpWrRetire),
      .fpWrAbort    (fpWrAbort),
      .fpExcValid   (fpExcValid),
      .fpExcCond    (fpExcCond),
      .fpTrapEn     (fpTrapEn),
      .fpCtlRd_r    (fpCtlRd_r),
      .trapEntry_r  (trapEntry_r),
      .excSummary_r (excSummary_r)
   );

   AST_SB_STALL: assert property (@(posedge clock) disable iff (!rst_b)
      mapValid && mapIsWrite && |(sbBits_r & mapSbMask) && !sameBlk
      |=> mapStall_r && !mapEnter_r)
      else $error("busy scoreboard writer not held");
   AST_SAME_BLK: assert property (@(posedge clock) disable iff (!rst_b)
      mapValid && mapIsRead && sameBlk && !fetchHold_r |=> mapEnter_r)
      else $error("same fetch block instruction held");
   AST_SB_SET: assert property (@(posedge clock) disable iff (!rst_b)
      mapValid && mapIsWrite && !fetchHold_r && !sbHit
      |=> (sbBits_r & $past(mapSbMask)) == $past(mapSbMask))
      else $error("scoreboard bits not set on entry");
   AST_BARRIER: assert property (@(posedge clock) disable iff (!rst_b)
      fetchHold_r && !stallRetRetire && !stallRetAbort |=> fetchHold_r)
      else $error("barrier released early");
   AST_BAR_ENTER: assert property (@(posedge clock) disable iff (!rst_b)
      fetchHold_r && mapValid && mapIsMem |=> !mapEnter_r)
      else $error("entry under barrier");
   AST_PRIV_GATE: assert property (@(posedge clock) disable iff (!rst_b)
      storeBubbleBusy |=> !privIssue_r)
      else $error("privileged access issued while store bubbles busy");
   AST_LOAD_GATE: assert property (@(posedge clock) disable iff (!rst_b)
      loadRdy && !loadBubbleBusy && loadSbDep == 4'h0 |=> loadIssue_r)
      else $error("load held by wrong busy");
   AST_SHADOW: assert property (@(posedge clock) disable iff (!rst_b)
      useShadow_r |-> $past(fwMode) && $past(shadowEnable[SDE_BIT]))
      else $error("shadow used outside firmware mode");
   AST_LINK: assert property (@(posedge clock) disable iff (!rst_b)
      fwCall && fwMode && shadowEnable[SDE_BIT] |=> linkWrite_r)
      else $error("call link write missing");
endmodule : ipr_access_ordering

//--- ipr_pkg.sv
// package with constants and types for internal register access ordering
package ipr_pkg;
   localparam int          SB_BITS      = 8;
   localparam int          SB_ISSUE_LO  = 0;
   localparam int          SB_ISSUE_W   = 4;
   localparam int          FBLK_LSB     = 4;
   localparam int          VA_W         = 16;
   localparam int          FP_W         = 6;
   localparam int          EXC_W        = 8;
   localparam int          SHADOW_N     = 8;
   localparam int          SDE_BIT      = 1;
   localparam logic [3:0]  SB_ISSUE_MSK = 4'hF;
   localparam logic [7:0]  SB_RST       = 8'h00;
   localparam logic [5:0]  FP_RST       = 6'h00;
   localparam logic [VA_W-1:0] VA_RST   = 16'h0000;
   localparam logic [1:0]  ENT_NONE     = 2'h0;
   localparam logic [1:0]  ENT_TRAP_ENTRY_A    = 2'h1;
   localparam logic [1:0]  ENT_FPWR     = 2'h2;
   typedef enum logic [1:0] {
      IPR_RUN   = 2'b00,
      IPR_STALL = 2'b01
   } ipr_barrier_t;
endpackage : ipr_pkg

//--- ipr_fp_ctl.sv
// floating-point control register: two latches, status and trap decision
`timescale 1ns/1ps
module ipr_fp_ctl
   import ipr_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // write instruction execute and retire
   input  wire logic             fpWrExec,
   input  wire logic [FP_W-1:0]  fpWrData,
   input  wire logic             fpWrRetire,
   input  wire logic             fpWrAbort,
   // exceptional conditions from the fp unit
   input  wire logic             fpExcValid,
   input  wire logic [FP_W-1:0]  fpExcCond,
   input  wire logic [FP_W-1:0]  fpTrapEn,
   // read path and trap outputs
   output logic      [FP_W-1:0]  fpCtlRd_r,
   output logic      [1:0]       trapEntry_r,
   output logic      [EXC_W-1:0] excSummary_r
);
   typedef struct packed {
      logic [FP_W-1:0]  first;
      logic [FP_W-1:0]  second;
      logic [1:0]       entry;
      logic [EXC_W-1:0] exc;
   } ipr_fp_t;
   ipr_fp_t st_r, st_nxt;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.entry = ENT_NONE;
      if (fpWrExec) begin
         st_nxt.first = fpWrData;
         st_nxt.entry = ENT_FPWR;
      end
      if (fpWrRetire) begin
         st_nxt.second = st_r.first;
      end else if (fpWrAbort) begin
         st_nxt.first = st_r.second;
      end
      if (fpExcValid) begin
         // status set regardless of trap enable; set wins over a retiring write
         st_nxt.second = st_nxt.second | fpExcCond;
         st_nxt.first  = st_nxt.first | fpExcCond;
         if (|(fpExcCond & (~st_r.second | fpTrapEn))) begin
            st_nxt.entry = ENT_TRAP_ENTRY_A;
            // low bits: all reported conditions, bit 6: enabled-trap flag, bit 7: always zero
            st_nxt.exc = {1'b0, |(fpExcCond & fpTrapEn), fpExcCond};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{first: FP_RST, second: FP_RST, entry: ENT_NONE, exc: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   // readers see only the retired copy; no fp-queue scoreboard orders them
   assign fpCtlRd_r    = st_r.second;
   assign trapEntry_r  = st_r.entry;
   assign excSummary_r = st_r.exc;

   AST_FP_RETIRE: assert property (@(posedge clock) disable iff (!rst_b)
      fpWrRetire && !fpExcValid |=> fpCtlRd_r == $past(st_r.first))
      else $error("fp second latch not copied on retire");
   AST_FP_WRTRAP: assert property (@(posedge clock) disable iff (!rst_b)
      fpWrExec && !fpExcValid |=> trapEntry_r == ENT_FPWR)
      else $error("fp write trap missing");
   AST_FP_STATUS: assert property (@(posedge clock) disable iff (!rst_b)
      fpExcValid |=> (fpCtlRd_r & $past(fpExcCond)) == $past(fpExcCond))
      else $error("fp status bit not set");
   AST_FP_TRAP_ENTRY_A: assert property (@(posedge clock) disable iff (!rst_b)
      fpExcValid && |(fpExcCond & ~fpCtlRd_r) |=> trapEntry_r == ENT_TRAP_ENTRY_A)
      else $error("trap_entry_a trap missing");
endmodule : ipr_fp_ctl

//--- ipr_far_side.sv
// far-side model: issue and retirement of an earlier writer, retirement of a stalling return
`timescale 1ns/1ps
module ipr_far_side
   import ipr_pkg::*;
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_b,
   // command from the bench: which bits, how slow, stalling return or writer
   input  wire logic               go,
   input  wire logic [SB_BITS-1:0] bits,
   input  wire logic [3:0]         dly,
   input  wire logic               isRet,
   // completion pulses into the block
   output logic      [SB_BITS-1:0] wrIssueBits,
   output logic      [SB_BITS-1:0] wrRetireBits,
   output logic                    stallRetRetire
);
   logic [3:0]         cnt;
   logic [SB_BITS-1:0] held;
   logic               ret;
   logic               pend;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         {cnt, held, ret, pend} <= '0;
         {wrIssueBits, wrRetireBits, stallRetRetire} <= '0;
      end else begin
         // retirement always trails issue by one cycle, never the reverse
         wrIssueBits    <= (cnt == 4'h1) ? held : 8'h00;
         stallRetRetire <= (cnt == 4'h1) && ret;
         pend           <= (cnt == 4'h1);
         wrRetireBits   <= pend ? held : 8'h00;
         if (go) begin
            cnt  <= dly;
            held <= bits;
            ret  <= isRet;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : ipr_far_side

//--- testbench.sv
// self-checking bench for the internal register access ordering block
`timescale 1ns/1ps
module testbench
   import ipr_pkg::*;
;
   logic clock, rst_b, mapValid, mapIsWrite, mapIsRead, mapIsMem, mapIsStallRet, u;
   logic privRdy, loadRdy, storeBubbleBusy, loadBubbleBusy, fwMode, fwCall, go, isRet;
   logic fpWrExec, fpWrRetire, fpWrAbort, fpExcValid, stallRetRetire, stallRetAbort;
   logic mapStall_r, mapEnter_r, fetchHold_r, privIssue_r, loadIssue_r, useShadow_r, linkWrite_r;
   logic [VA_W-1:0]    mapAddr;
   logic [SB_BITS-1:0] mapSbMask, wrIssueBits, wrRetireBits, sbBits_r, bits, wrAbortBits;
   logic [SB_ISSUE_W-1:0] loadSbDep;
   logic [1:0]         shadowEnable, trapEntry_r;
   logic [4:0]         srcReg;
   logic [2:0]         shadowIdx_r;
   logic [3:0]         dly;
   logic [FP_W-1:0]    fpWrData, fpExcCond, fpTrapEn, fpCtlRd_r;
   logic [EXC_W-1:0]   excSummary_r;
   logic [31:0]        rv;
   logic [3:0]         notes[$];
   int                 errorCnt = 0, nCompared = 0, cycles = 0, i;
   integer             seed = 32'h4bdb;

   ipr_access_ordering i_dut (.*);
   ipr_far_side i_far (.*);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic closeOut();
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : closeOut

   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   // a request stands one cycle; the note says whether it should enter or be held
   task automatic mapReq(input logic [VA_W-1:0] a, input logic [3:0] k,
                         input logic [SB_BITS-1:0] m, input logic ent);
      @(posedge clock);
      mapValid <= 1'b1;
      mapAddr <= a;
      {mapIsWrite, mapIsRead, mapIsMem, mapIsStallRet} <= k;
      mapSbMask <= m;
      notes.push_back({ent, ~ent, 2'h0});
   endtask : mapReq

   task automatic mapIdle();
      @(posedge clock);
      mapValid <= 1'b0;
      #1;
   endtask : mapIdle

   task automatic farRun(input logic [SB_BITS-1:0] b, input logic [3:0] d, input logic r);
      int n;
      @(posedge clock);
      {go, bits, dly, isRet} <= {1'b1, b, d, r};
      @(posedge clock);
      go <= 1'b0;
      #1;
      for (n = 0; n < 20 && wrIssueBits === 8'h00 && stallRetRetire !== 1'b1; n++) tick();
   endtask : farRun

   task automatic fpWr(input logic [FP_W-1:0] d, input logic ab, input logic [FP_W-1:0] old,
                       input logic [FP_W-1:0] expRd);
      @(posedge clock);
      fpWrExec <= 1'b1;
      fpWrData <= d;
      notes.push_back(4'h2);
      @(posedge clock);
      {fpWrExec, fpWrRetire, fpWrAbort} <= {1'b0, ~ab, ab};
      #1 chk(fpCtlRd_r, old, "fp ctl before retire");
      @(posedge clock);
      {fpWrRetire, fpWrAbort} <= 2'b00;
      #1 chk(fpCtlRd_r, expRd, "fp ctl after retire");
   endtask : fpWr

   task automatic fpExc(input logic [FP_W-1:0] c, input logic [FP_W-1:0] en, input logic t);
      @(posedge clock);
      {fpExcValid, fpExcCond, fpTrapEn} <= {1'b1, c, en};
      if (t) notes.push_back(4'h1);
      @(posedge clock);
      fpExcValid <= 1'b0;
      #1;
   endtask : fpExc

   // one note is consumed per map answer or trap seen
   always @(posedge clock) begin
      #1;
      if (rst_b === 1'b1 && (mapEnter_r !== 1'b0 || mapStall_r !== 1'b0 || trapEntry_r !== 2'h0))
         chk({mapEnter_r, mapStall_r, trapEntry_r}, notes.size() ? notes.pop_front() : 4'h0,
             "map or trap event");
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errorCnt++;
         closeOut();
      end
   end

   initial begin
      {mapValid, mapIsWrite, mapIsRead, mapIsMem, mapIsStallRet, privRdy, loadRdy, go, isRet,
       storeBubbleBusy, loadBubbleBusy, fwMode, fwCall, fpWrExec, fpWrRetire, fpWrAbort,
       fpExcValid} = '0;
      {mapAddr, mapSbMask, shadowEnable, srcReg, bits, dly, fpWrData, fpExcCond, fpTrapEn} = '0;
      {wrAbortBits, loadSbDep, stallRetAbort} = '0;
      rst_b = 1'b0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      tick();
      chk({sbBits_r, fetchHold_r, fpCtlRd_r}, 16'h0000, "after reset");
      mapReq(16'h0100, 4'h8, 8'h11, 1'b1);
      // same fetch block on purpose, although firmware would not do this
      mapReq(16'h0108, 4'h8, 8'h01, 1'b1);
      mapReq(16'h010C, 4'h4, 8'h01, 1'b1);
      mapReq(16'h0110, 4'h2, 8'h01, 1'b0);
      mapReq(16'h0110, 4'h4, 8'h10, 1'b0);
      mapReq(16'h0110, 4'h8, 8'h10, 1'b0);
      mapIdle();
      chk(sbBits_r, 8'h11, "scoreboard set");
      farRun(8'h11, 4'h3, 1'b0);
      tick();
      chk(sbBits_r, 8'h10, "low bits clear on issue");
      tick();
      chk(sbBits_r, 8'h00, "high bits clear on retire");
      mapReq(16'h0110, 4'h2, 8'h01, 1'b1);
      mapReq(16'h0120, 4'h8, 8'h10, 1'b1);
      mapIdle();
      farRun(8'h10, 4'h1, 1'b0);
      tick();
      tick();
      chk(sbBits_r, 8'h00, "scoreboard empty");
      $display("test scoreboard done");
      mapReq(16'h0200, 4'h3, 8'h00, 1'b1);
      mapReq(16'h0210, 4'h8, 8'h00, 1'b0);
      mapIdle();
      chk(fetchHold_r, 1'b1, "barrier up");
      farRun(8'h00, 4'h2, 1'b1);
      tick();
      chk(fetchHold_r, 1'b0, "barrier down");
      mapReq(16'h0220, 4'h8, 8'h00, 1'b1);
      mapIdle();
      $display("test barrier done");
      mapReq(16'h0230, 4'h8, 8'h22, 1'b1);
      mapReq(16'h0240, 4'h3, 8'h00, 1'b1);
      mapReq(16'h0250, 4'h2, 8'h00, 1'b0);
      mapIdle();
      @(posedge clock);
      {loadRdy, loadBubbleBusy, loadSbDep} <= {2'b10, 4'h2};
      tick();
      chk({loadIssue_r, fetchHold_r, sbBits_r}, {2'b01, 8'h22}, "load held behind writer");
      @(posedge clock);
      {wrAbortBits, stallRetAbort} <= {8'h22, 1'b1};
      @(posedge clock);
      {wrAbortBits, stallRetAbort} <= 9'h000;
      #1 chk({loadIssue_r, fetchHold_r, sbBits_r}, 10'h000, "abort clears bits and barrier");
      tick();
      chk(loadIssue_r, 1'b1, "load after abort");
      $display("test abort done");
      for (i = 0; i < 16; i++) begin
         @(posedge clock);
         rv = $random(seed);
         {loadSbDep, privRdy, loadRdy, storeBubbleBusy, loadBubbleBusy} <= {4'h0, rv[3:0]};
         tick();
         chk({privIssue_r, loadIssue_r}, {rv[3] & ~rv[1], rv[2] & ~rv[0]}, "issue");
      end
      $display("test issue gates done");
      for (i = 0; i < 32; i++) begin
         @(posedge clock);
         rv = $random(seed);
         srcReg <= i[4:0];
         fwMode <= rv[0] | rv[1];
         shadowEnable <= {rv[2] | rv[3], rv[4]};
         tick();
         u = fwMode & shadowEnable[1] & (srcReg[3:2] == 2'b01);
         chk({useShadow_r, u ? shadowIdx_r : 3'h0},
             {u, u ? {srcReg[4], srcReg[1:0]} : 3'h0}, "shadow map");
      end
      // mode and enable are left random by the loop above, so pin them down
      @(posedge clock);
      {fwCall, fwMode, shadowEnable} <= {2'b11, 2'b10};
      @(posedge clock);
      {fwCall, fwMode} <= 2'b10;
      #1 chk(linkWrite_r, 1'b1, "link write");
      @(posedge clock);
      fwCall <= 1'b0;
      #1 chk(linkWrite_r, 1'b0, "no link outside firmware mode");
      $display("test shadow done");
      fpExc(6'h01, 6'h00, 1'b1);
      chk(excSummary_r[6:0], 7'h01, "summary untrapped");
      // the exception above already set status bit 0 in the retired copy
      fpWr(6'h3F, 1'b0, 6'h01, 6'h3F);
      fpWr(6'h15, 1'b1, 6'h3F, 6'h3F);
      fpExc(6'h01, 6'h00, 1'b0);
      fpExc(6'h01, 6'h01, 1'b1);
      chk(excSummary_r[6:0], 7'h41, "summary trapped");
      chk(fpCtlRd_r, 6'h3F, "fp ctl read");
      tick();
      chk(16'(notes.size()), 16'h0000, "answers missing");
      $display("test fp control done");
      closeOut();
   end
endmodule : testbench
